// *** core/txpf_cfg.svh ***
/*
 * Constants for the transaction-aware event filter: field positions,
 * event encodings, record offsets and reset values.
 * Assumes inclusion by the package and the design modules.
 */
`ifndef TXPF_CFG_SVH
`define TXPF_CFG_SVH

// ==========================================================
// Event select fields
`define TXPF_SEL_IN_REGION_BIT   32
`define TXPF_SEL_CHECKPOINT_BIT  33
`define TXPF_SEL_CODE_LSB        0
`define TXPF_SEL_UMASK_LSB       8
`define TXPF_SEL_EN_BIT          22
`define TXPF_CKPT_COUNTER        2

// ==========================================================
// Abortable event encodings
`define TXPF_EV_ELIDED_CODE      8'hC8
`define TXPF_EV_RESTR_CODE       8'hC9
`define TXPF_EV_ABORT_UMASK      8'h04

// ==========================================================
// Record entry offsets
`define TXPF_REC_IP_OFS          8'h08
`define TXPF_REC_SIP_OFS         8'hB0
`define TXPF_REC_ABORT_OFS       8'hB8

// ==========================================================
// Abort-information word layout
`define TXPF_AI_CYC_MSB          31
`define TXPF_AI_ELIDED_BIT       32
`define TXPF_AI_RESTR_BIT        33
`define TXPF_AI_INSN_BIT         34
`define TXPF_AI_NONINSN_BIT      35
`define TXPF_AI_RETRY_BIT        36
`define TXPF_AI_CONFLICT_BIT     37
`define TXPF_AI_CAPW_BIT         38
`define TXPF_AI_CAPR_BIT         39
`define TXPF_AI_SUSP_BIT         40

// ==========================================================
// Reset values
`define TXPF_CNT_RESET           48'h0000_0000_0000
`define TXPF_WORD_RESET          64'h0000_0000_0000_0000

`endif

// *** core/txpf_pkg.sv ***
/*
 * Types shared by the transaction-aware event filter.
 * Assumes the constants header is on the include path.
 */
`include "txpf_cfg.svh"

package txpf_pkg;

	typedef enum logic [1:0] {
		TXPF_MODE_NONE   = 2'b00,
		TXPF_MODE_ELIDED = 2'b01,
		TXPF_MODE_RESTR  = 2'b10
	} txpf_mode_t;

	// Abort cause flags reported by the core at an abort
	typedef struct packed {
		logic insnTied;
		logic insnUnrelated;
		logic retry;
		logic conflict;
		logic capWrites;
		logic capReads;
		logic inSuspend;
	} txpf_cause_t;

	// Sample record as seen by software
	typedef struct packed {
		logic        valid;
		logic        abortRecord;
		logic [63:0] regionIp;
		logic [63:0] sampledIp;
		logic [63:0] abortInfo;
	} txpf_record_t;

	// Restart direction given back to the core
	typedef struct packed {
		logic        valid;
		logic        toFallback;
		logic [63:0] target;
	} txpf_restart_t;

endpackage

// *** core/txpf_counter.sv ***
/*
 * One filtered performance counter with optional checkpoint.
 * Assumes event pulses and region flags synchronous to mclk.
 */
`timescale 1ns/10ps
`include "txpf_cfg.svh"

module txpf_counter (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        enable,
	input  wire logic        inRegionOnly,
	input  wire logic        checkpointOn,
	input  wire logic        eventHit,
	input  wire logic        inRegion,
	input  wire logic        regionBegin,
	input  wire logic        regionAbort,
	output logic [47:0]      count_q,
	output logic             overflow_q
);

	logic [47:0] ckpt_q;
	logic        pass;
	logic [48:0] sum;

	// ==========================================================
	// Filtering
	assign pass = enable && eventHit && (!inRegionOnly || inRegion);
	assign sum  = {1'b0, count_q} + 49'h1;

	// ==========================================================
	// Checkpoint taken when the region opens
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ckpt_q <= `TXPF_CNT_RESET;
		end else if (regionBegin) begin
			ckpt_q <= count_q;
		end
	end

	// ==========================================================
	// Count; abort rollback wins over an increment in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_q    <= `TXPF_CNT_RESET;
			overflow_q <= 1'b0;
		end else if (checkpointOn && regionAbort) begin
			count_q    <= ckpt_q;
			overflow_q <= 1'b0;
		end else if (pass) begin
			count_q    <= sum[47:0];
			overflow_q <= sum[48];
		end else begin
			overflow_q <= 1'b0;
		end
	end

endmodule

// *** core/tx_aware_perf_event_filter.sv ***
/*
 * Transaction-aware performance counter filter and sample-record builder.
 * Assumes the core supplies region begin/commit/abort pulses, abort
 * causes, region and fallback addresses, all synchronous to mclk.
 */
`timescale 1ns/10ps
`include "txpf_cfg.svh"

module tx_aware_perf_event_filter #(
	parameter int NUM_CNT = 4,
	parameter bit HAS_SUSPEND = 1'b0
) (
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	input  wire logic [NUM_CNT-1:0][63:0] eventSelect,
	input  wire logic [NUM_CNT-1:0][7:0]  eventCode,
	input  wire logic [NUM_CNT-1:0]       eventHit,
	input  wire logic                     txSupported,
	input  wire logic                     regionBegin,
	input  wire txpf_pkg::txpf_mode_t     regionMode,
	input  wire logic [63:0]              regionStartIp,
	input  wire logic [63:0]              fallbackIp,
	input  wire logic                     regionCommit,
	input  wire logic                     coreAbort,
	input  wire txpf_pkg::txpf_cause_t    abortCause,
	input  wire logic [63:0]              sampledIp,
	input  wire logic                     sampleRequest,
	input  wire logic                     recordAck,
	output logic [NUM_CNT-1:0][47:0]      counterValue_q,
	output logic                          forceAbort_q,
	output txpf_pkg::txpf_restart_t       restart_q,
	output txpf_pkg::txpf_record_t        record_q,
	output logic                          inRegion_q
);

	txpf_pkg::txpf_mode_t mode_q;
	logic [31:0]          cycles_q;
	logic [63:0]          startIp_q;
	logic [63:0]          fbIp_q;
	logic                 pending_q;
	logic [63:0]          pendIp_q;
	logic                 abortNow;
	logic                 anyAbortOvf;
	logic [NUM_CNT-1:0]   overflow;
	logic [NUM_CNT-1:0][47:0] cnt;

	// ==========================================================
	// Decoders
	function automatic logic is_abort_event(input logic [63:0] sel);
		logic [7:0] code;
		logic [7:0] umask;
		code  = sel[`TXPF_SEL_CODE_LSB +: 8];
		umask = sel[`TXPF_SEL_UMASK_LSB +: 8];
		is_abort_event = umask == `TXPF_EV_ABORT_UMASK &&
			(code == `TXPF_EV_ELIDED_CODE || code == `TXPF_EV_RESTR_CODE);
	endfunction

	// Support comes in as an argument so the port expressions follow its changes
	function automatic logic filter_bit(input logic [63:0] sel, input logic supported,
		input logic ckpt, input int idx);
		// Filters ignored without transactional support
		if (!supported) begin
			filter_bit = 1'b0;
		end else if (ckpt) begin
			filter_bit = sel[`TXPF_SEL_CHECKPOINT_BIT] && idx == `TXPF_CKPT_COUNTER;
		end else begin
			filter_bit = sel[`TXPF_SEL_IN_REGION_BIT];
		end
	endfunction

	// ==========================================================
	// Abort sources: core abort, pended sample or new sample request inside region
	assign abortNow = inRegion_q && (coreAbort || pending_q || sampleRequest);

	// ==========================================================
	// Counters
	generate
		for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
			txpf_counter u_cnt (
				.mclk         (mclk),
				.rst_n        (rst_n),
				.enable       (eventSelect[i][`TXPF_SEL_EN_BIT]),
				.inRegionOnly (filter_bit(eventSelect[i], txSupported, 1'b0, i)),
				.checkpointOn (filter_bit(eventSelect[i], txSupported, 1'b1, i)),
				.eventHit     (eventHit[i]),
				.inRegion     (inRegion_q),
				.regionBegin  (regionBegin && !inRegion_q),
				.regionAbort  (abortNow),
				.count_q      (cnt[i]),
				.overflow_q   (overflow[i])
			);
		end
	endgenerate

	always_comb begin
		anyAbortOvf = 1'b0;
		for (int k = 0; k < NUM_CNT; k++) begin
			if (overflow[k] && is_abort_event(eventSelect[k])) begin
				anyAbortOvf = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			counterValue_q <= '0;
		end else begin
			counterValue_q <= cnt;
		end
	end

	// ==========================================================
	// Region tracking and cycle count of latest region
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			inRegion_q <= 1'b0;
			mode_q     <= txpf_pkg::TXPF_MODE_NONE;
			cycles_q   <= 32'h0000_0000;
			startIp_q  <= 64'h0000_0000_0000_0000;
			fbIp_q     <= 64'h0000_0000_0000_0000;
		end else if (abortNow || (inRegion_q && regionCommit)) begin
			inRegion_q <= 1'b0;
		end else if (regionBegin && !inRegion_q) begin
			// Nested begins keep the outermost region's addresses
			inRegion_q <= 1'b1;
			mode_q     <= regionMode;
			cycles_q   <= 32'h0000_0001;
			startIp_q  <= regionStartIp;
			fbIp_q     <= fallbackIp;
		end else if (inRegion_q) begin
			cycles_q   <= cycles_q + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Sample inside a region aborts it in the same cycle, so pending_q never sets
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= 1'b0;
			pendIp_q  <= 64'h0000_0000_0000_0000;
		end else if (abortNow) begin
			pending_q <= 1'b0;
		end else if (sampleRequest && !inRegion_q) begin
			pending_q <= 1'b0;
		end else if (sampleRequest) begin
			pending_q <= 1'b1;
			pendIp_q  <= sampledIp;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			forceAbort_q <= 1'b0;
		end else begin
			forceAbort_q <= inRegion_q && (pending_q || sampleRequest) && !coreAbort;
		end
	end

	// ==========================================================
	// Restart direction after an abort
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			restart_q <= '0;
		end else begin
			restart_q.valid      <= abortNow;
			restart_q.toFallback <= abortNow && mode_q == txpf_pkg::TXPF_MODE_RESTR;
			restart_q.target     <= (mode_q == txpf_pkg::TXPF_MODE_RESTR) ? fbIp_q
				: startIp_q;
		end
	end

	// ==========================================================
	// Record builder; a new record overwrites, software acks to clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			record_q <= '0;
		end else if (abortNow && (pending_q || sampleRequest || anyAbortOvf)) begin
			record_q.valid       <= 1'b1;
			record_q.abortRecord <= 1'b1;
			record_q.regionIp    <= (mode_q == txpf_pkg::TXPF_MODE_RESTR) ? fbIp_q
				: startIp_q;
			record_q.sampledIp   <= (pending_q ? pendIp_q : sampledIp);
			record_q.abortInfo   <= `TXPF_WORD_RESET;
			record_q.abortInfo[`TXPF_AI_CYC_MSB:0] <= cycles_q;
			record_q.abortInfo[`TXPF_AI_ELIDED_BIT] <= mode_q == txpf_pkg::TXPF_MODE_ELIDED;
			record_q.abortInfo[`TXPF_AI_RESTR_BIT]  <= mode_q == txpf_pkg::TXPF_MODE_RESTR;
			record_q.abortInfo[`TXPF_AI_INSN_BIT]    <= coreAbort && abortCause.insnTied;
			record_q.abortInfo[`TXPF_AI_NONINSN_BIT] <= !coreAbort || abortCause.insnUnrelated;
			record_q.abortInfo[`TXPF_AI_RETRY_BIT]    <= !coreAbort || abortCause.retry;
			record_q.abortInfo[`TXPF_AI_CONFLICT_BIT] <= coreAbort && abortCause.conflict;
			record_q.abortInfo[`TXPF_AI_CAPW_BIT]     <= coreAbort && abortCause.capWrites;
			record_q.abortInfo[`TXPF_AI_CAPR_BIT]     <= coreAbort && abortCause.capReads;
			record_q.abortInfo[`TXPF_AI_SUSP_BIT]     <= HAS_SUSPEND && coreAbort
				&& abortCause.inSuspend;
		end else if (sampleRequest && !inRegion_q) begin
			record_q.valid       <= 1'b1;
			record_q.abortRecord <= 1'b0;
			record_q.regionIp    <= sampledIp;
			record_q.sampledIp   <= sampledIp;
			record_q.abortInfo   <= `TXPF_WORD_RESET;
			record_q.abortInfo[`TXPF_AI_CYC_MSB:0] <= cycles_q;
		end else if (recordAck) begin
			record_q.valid <= 1'b0;
		end
	end

endmodule

// *** bench/txpf_props.sv ***
/* Checker for the event filter top, bound by name.
   Assumes one clock domain; the counter count comes from the bound top. */
`timescale 1ns/10ps
// ========
// Checker
module txpf_props #(
	parameter int NUM_CNT = 4
) (
	input wire logic                     mclk,
	input wire logic                     rst_n,
	input wire logic [NUM_CNT-1:0][63:0] eventSelect,
	input wire logic [NUM_CNT-1:0]       eventHit,
	input wire logic                     txSupported,
	input wire logic                     regionBegin,
	input wire logic                     coreAbort,
	input wire txpf_pkg::txpf_cause_t    abortCause,
	input wire logic                     sampleRequest,
	input wire logic                     recordAck,
	input wire logic [NUM_CNT-1:0][47:0] counterValue_q,
	input wire logic                     forceAbort_q,
	input wire txpf_pkg::txpf_restart_t  restart_q,
	input wire txpf_pkg::txpf_record_t   record_q,
	input wire logic                     inRegion_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [5:0] causeBits;
	logic       abortNow;
	assign causeBits = {abortCause.capReads, abortCause.capWrites, abortCause.conflict,
		abortCause.retry, abortCause.insnUnrelated, abortCause.insnTied};
	assign abortNow = inRegion_q && (coreAbort || sampleRequest || forceAbort_q);
	sequence abortSeq;
		inRegion_q && coreAbort && sampleRequest;
	endsequence
	sequence recordSeq;
		record_q.valid && record_q.abortRecord && !inRegion_q;
	endsequence
	property forcedP;
		inRegion_q && sampleRequest && !coreAbort |=>
			recordSeq ##0 record_q.abortInfo[36:35] == 2'h3;
	endproperty
	property restartP;
		abortNow |=> restart_q.valid && !inRegion_q ##1 !restart_q.valid;
	endproperty
	property inOnlyP;
		eventSelect[0][32] && eventSelect[0][22] && txSupported && eventHit[0] &&
			!inRegion_q && !regionBegin |=> ##1 $stable(counterValue_q[0]);
	endproperty
	abort_record_a: assert property (abortSeq |=> recordSeq)
		else $error("abort left no abort record");
	cause_bits_a: assert property (abortSeq |=> record_q.abortInfo[39:34] == $past(causeBits))
		else $error("abort cause bits differ from core causes");
	forced_abort_a: assert property (forcedP)
		else $error("sample in region did not abort first");
	reserved_zero_a: assert property (record_q.valid |-> record_q.abortInfo[63:41] == '0)
		else $error("reserved abort bits not zero");
	mode_flags_a: assert property (recordSeq |-> record_q.abortInfo[32] != record_q.abortInfo[33])
		else $error("abort mode flags not one-hot");
	restart_pulse_a: assert property (restartP)
		else $error("restart not a single pulse after abort");
	record_stand_a: assert property (record_q.valid && !recordAck |=> record_q.valid)
		else $error("record dropped without acknowledge");
	in_region_only_a: assert property (inOnlyP)
		else $error("filtered counter moved outside a region");
endmodule

bind tx_aware_perf_event_filter txpf_props #(.NUM_CNT(NUM_CNT)) u_props (
	.mclk, .rst_n, .eventSelect, .eventHit, .txSupported, .regionBegin, .coreAbort,
	.abortCause, .sampleRequest, .recordAck, .counterValue_q, .forceAbort_q,
	.restart_q, .record_q, .inRegion_q);

// *** bench/txpf_core_model.sv ***
/* Core-side model: region begin, end and sample pulses.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/10ps
// ========
// Core model
module txpf_core_model (
	input  wire logic            mclk,
	output logic                 regionBegin,
	output logic                 regionCommit,
	output logic                 coreAbort,
	output logic                 sampleRequest,
	output txpf_pkg::txpf_mode_t regionMode,
	output txpf_pkg::txpf_cause_t abortCause,
	output logic [63:0]          regionStartIp,
	output logic [63:0]          fallbackIp,
	output logic [63:0]          sampledIp
);
	initial begin
		{regionBegin, regionCommit, coreAbort, sampleRequest} = 4'h0;
		regionMode = txpf_pkg::TXPF_MODE_NONE;
		abortCause = '0;
		{regionStartIp, fallbackIp, sampledIp} = '0;
	end
	task automatic start(input txpf_pkg::txpf_mode_t m, input logic [63:0] s, f);
		@(posedge mclk);
		regionBegin <= 1'b1;
		regionMode <= m;
		regionStartIp <= s;
		fallbackIp <= f;
		@(posedge mclk);
		regionBegin <= 1'b0;
		// Stale after capture, so a late sample shows up
		regionStartIp <= ~s;
		fallbackIp <= ~f;
	endtask
	// Kind 0 commit, 1 abort, 2 precise sample request, 3 abort with a sample request in the same cycle
	task automatic finish(input logic [1:0] k, input txpf_pkg::txpf_cause_t c, input logic [63:0] ip);
		@(posedge mclk);
		regionCommit <= k == 2'h0;
		coreAbort <= k[0];
		sampleRequest <= k[1];
		abortCause <= c;
		sampledIp <= ip;
		@(posedge mclk);
		{regionCommit, coreAbort, sampleRequest} <= 3'h0;
		abortCause <= ~c;
		sampledIp <= ~ip;
	endtask
endmodule

// *** bench/tb_tx_aware_perf_event_filter.sv ***
/* Self-checking bench: filter, core model and bound checker.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/10ps
// ========
// Bench
module tb_tx_aware_perf_event_filter;
	localparam logic [63:0] SIP = 64'h0000_0000_0000_1000;
	localparam logic [63:0] FIP = 64'h0000_0000_0000_2000;
	logic                    mclk, rst_n, txSupported, recordAck;
	logic                    regionBegin, regionCommit, coreAbort, sampleRequest;
	logic [3:0][63:0]        eventSelect;
	logic [3:0]              eventHit;
	txpf_pkg::txpf_mode_t    regionMode;
	txpf_pkg::txpf_cause_t   abortCause;
	logic [63:0]             regionStartIp, fallbackIp, sampledIp;
	logic [3:0][47:0]        counterValue_q;
	logic                    inRegion_q, forceAbort_q;
	txpf_pkg::txpf_restart_t restart_q;
	txpf_pkg::txpf_record_t  record_q;
	logic [47:0]             expCnt [4];
	logic [31:0]             cyA, cyB;
	int                      n_fail, n_checks, cyc;
	tx_aware_perf_event_filter #(.NUM_CNT(4), .HAS_SUSPEND(1'b0)) dut (.mclk, .rst_n,
		.eventSelect, .eventCode('0), .eventHit, .txSupported, .regionBegin, .regionMode,
		.regionStartIp, .fallbackIp, .regionCommit, .coreAbort, .abortCause, .sampledIp,
		.sampleRequest, .recordAck, .counterValue_q, .forceAbort_q, .restart_q,
		.record_q, .inRegion_q);
	txpf_core_model core (.mclk, .regionBegin, .regionCommit, .coreAbort, .sampleRequest,
		.regionMode, .abortCause, .regionStartIp, .fallbackIp, .sampledIp);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Mask marks counters whose net count must grow by n
	task automatic hits(input int n, input logic [3:0] m);
		@(posedge mclk);
		eventHit <= 4'hF;
		repeat (n) @(posedge mclk);
		eventHit <= 4'h0;
		for (int i = 0; i < 4; i++)
			if (m[i]) expCnt[i] += 48'(n);
	endtask
	task automatic cmp_cnt();
		repeat (2) @(posedge mclk);
		#1;
		for (int i = 0; i < 4; i++)
			chk("counter", counterValue_q[i], expCnt[i]);
	endtask
	task automatic t_abort(input txpf_pkg::txpf_mode_t md, input txpf_pkg::txpf_cause_t c,
		input logic [5:0] bits, input int n, input logic [3:0] m, output logic [31:0] cy);
		logic r;
		r = md == txpf_pkg::TXPF_MODE_RESTR;
		core.start(md, SIP, FIP);
		hits(n, m);
		// A plain abort builds no record, so a sample is requested in the same cycle
		core.finish(2'h3, c, SIP + 64'h10);
		#1;
		chk("restart", {restart_q.valid, restart_q.toFallback}, {1'b1, r});
		chk("restart target", restart_q.target, r ? FIP : SIP);
		chk("abort record", {record_q.valid, record_q.abortRecord}, 2'h3);
		chk("region ip", record_q.regionIp, r ? FIP : SIP);
		chk("abort mode", record_q.abortInfo[33:32], {r, !r});
		chk("abort cause", record_q.abortInfo[39:34], bits);
		chk("reserved", record_q.abortInfo[63:40], 24'h0);
		chk("abort sampled ip", record_q.sampledIp, SIP + 64'h10);
		chk("force on core abort", forceAbort_q, 1'b0);
		cy = record_q.abortInfo[31:0];
		cmp_cnt();
	endtask
	task automatic t_outside();
		hits(3, 4'hE);
		core.finish(2'h2, '0, 64'h0000_0000_0000_4000);
		#1;
		chk("outside record", {record_q.valid, record_q.abortRecord, inRegion_q}, 3'h4);
		chk("outside ip", record_q.sampledIp, 64'h0000_0000_0000_4000);
		cmp_cnt();
	endtask
	task automatic t_sample();
		core.start(txpf_pkg::TXPF_MODE_ELIDED, SIP, FIP);
		hits(2, 4'hB);
		core.finish(2'h2, '0, 64'h0000_0000_0000_3000);
		#1;
		chk("forced abort", {inRegion_q, record_q.abortInfo[36:32]}, 6'h19);
		chk("sampled ip", record_q.sampledIp, 64'h0000_0000_0000_3000);
		chk("force abort", forceAbort_q, 1'b1);
		cmp_cnt();
	endtask
	task automatic t_commit();
		@(posedge mclk);
		recordAck <= 1'b1;
		@(posedge mclk);
		recordAck <= 1'b0;
		core.start(txpf_pkg::TXPF_MODE_RESTR, SIP, FIP);
		hits(5, 4'hF);
		core.finish(2'h0, '0, SIP);
		#1;
		chk("commit leaves no record", {record_q.valid, inRegion_q}, 2'h0);
		cmp_cnt();
		// Abort with nothing pended: restart only, no record
		core.start(txpf_pkg::TXPF_MODE_ELIDED, SIP, FIP);
		core.finish(2'h1, 7'h08, SIP);
		#1;
		chk("plain abort", {record_q.valid, restart_q.valid, inRegion_q}, 3'h2);
		chk("plain restart target", restart_q.target, SIP);
	endtask
	task automatic t_unsupported();
		@(posedge mclk);
		txSupported <= 1'b0;
		hits(2, 4'hF);
		cmp_cnt();
		t_abort(txpf_pkg::TXPF_MODE_RESTR, 7'h20, 6'h02, 2, 4'hF, cyA);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{n_fail, n_checks, cyc} = '0;
		{rst_n, recordAck, eventHit} = '0;
		txSupported = 1'b1;
		// Counter two alone checkpoints; the checkpoint on three must be ignored
		eventSelect = {64'h0000_0002_0040_04C8, 64'h0000_0002_0040_04C9,
			64'h0000_0000_0040_0011, 64'h0000_0001_0040_04C8};
		for (int i = 0; i < 4; i++)
			expCnt[i] = 48'h0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_outside();
		t_abort(txpf_pkg::TXPF_MODE_RESTR, 7'h45, 6'h11, 4, 4'hB, cyA);
		t_abort(txpf_pkg::TXPF_MODE_ELIDED, 7'h12, 6'h24, 2, 4'hB, cyB);
		chk("cycle delta", cyA - cyB, 32'h2);
		t_sample();
		t_commit();
		t_unsupported();
		report_and_stop();
	end
endmodule
